/* File: design/peer_relay_clock_defs.vh */
// Constants for the peer relay clock stamping block.
`ifndef PEER_RELAY_CLOCK_DEFS_VH
`define PEER_RELAY_CLOCK_DEFS_VH
// Message kinds delivered by the frame analyzer.
`define KIND_W          2
`define KIND_SYNC       2'h0
`define KIND_PDREQ      2'h1
`define KIND_PDRESP     2'h2
`define KIND_OTHER      2'h3
// Field widths.
`define CF_W            64
`define NS_W            32
`define SEQ_W           16
`define OFS_W           8
`define SIZE_W          4
// Fraction bits of a scaled-nanosecond correction value.
`define CF_FRAC_W       16
// Nanoseconds in one second, for sub-second wrap.
`define NS_PER_SEC      32'h3b9aca00
// Byte offsets inside the PTP header and write sizes.
`define OFS_CF          8'h08
`define OFS_RSV         8'h10
`define OFS_NONE        8'h00
`define SIZE_CF         4'h8
`define SIZE_RSV        4'h4
`define SIZE_NONE       4'h0
// Timestamp FIFO geometry.
`define FIFO_DEPTH      8
`define FIFO_AW         3
// Reset values.
`define RST_CF          64'h0000000000000000
`define RST_NS          32'h00000000
`endif

/* File: design/peer_relay_clock_stamp.v */
// Peer relay clock timestamp unit with its transmit timestamp FIFO.
`timescale 1ns/1ns
`include "peer_relay_clock_defs.vh"

// Flip-flop FIFO with valid and ready on both sides.
module ts_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             push;
    wire             pop;
    genvar           i;

    // Full and empty come straight from the fill count.
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];

    // Pointers and count; depth is a power of two so pointers wrap.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // One storage word per entry.
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_q[i] <= {WIDTH{1'b0}};
                end else if (push && (wr_q == i[AW-1:0])) begin
                    mem_q[i] <= in_data;
                end
            end
        end
    endgenerate
endmodule // ts_fifo

// Timestamp unit: picks the action per frame and forms the new fields.
module peer_relay_clock_stamp (
    input  wire                  CLK_SYS,
    input  wire                  RST_B,
    input  wire                  MODE_B,
    input  wire                  T3_QUEUE,
    input  wire [`NS_W-1:0]      LINK_DELAY_NS,
    input  wire [`NS_W-1:0]      ASYM_NS,
    input  wire [`NS_W-1:0]      LOCAL_CORR_NS,
    input  wire                  FRM_VALID,
    output wire                  FRM_READY,
    input  wire                  FRM_EGRESS,
    input  wire                  FRM_MATCH,
    input  wire [`KIND_W-1:0]    FRM_KIND,
    input  wire [`CF_W-1:0]      FRM_CF,
    input  wire [`NS_W-1:0]      FRM_RSV,
    input  wire [`SEQ_W-1:0]     FRM_SEQ,
    input  wire                  FRM_FCS_BAD,
    input  wire [`NS_W-1:0]      CAPTURED_TIME_NS,
    output wire                  RW_VALID,
    input  wire                  RW_READY,
    output reg  [`OFS_W-1:0]     RW_OFFSET,
    output reg  [`SIZE_W-1:0]    RW_SIZE,
    output reg  [`CF_W-1:0]      RW_NEW_FIELD,
    output reg                   RW_CF_EXTRA,
    output reg  [`CF_W-1:0]      RW_CF_EXTRA_VAL,
    output reg                   RW_RSV_CLEAR,
    output reg                   RW_FCS_REDO,
    output reg                   RW_FCS_INVERT,
    output reg                   RW_TS_FLUSH,
    output wire                  FIFO_VALID,
    input  wire                  FIFO_READY,
    output wire [`SEQ_W-1:0]     FIFO_SEQ,
    output wire [`NS_W-1:0]      FIFO_TS_NS
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    reg  [1:0]           state_q;
    reg  [1:0]           state_d;
    reg  [`OFS_W-1:0]    ofs_d;
    reg  [`SIZE_W-1:0]   size_d;
    reg  [`CF_W-1:0]     field_d;
    reg                  extra_d;
    reg  [`CF_W-1:0]     extra_val_d;
    reg                  clr_d;
    reg                  flush_d;
    reg                  queue_d;
    reg  [`NS_W-1:0]     queue_ts_d;
    wire                 take;
    wire                 fifo_in_ready;
    wire [`NS_W-1:0]     live_time_nanoseconds;
    wire [`NS_W-1:0]     live_time_nanoseconds_peer;
    wire [`NS_W-1:0]     resid_ns;
    wire [`CF_W-1:0]     live_sc;
    wire [`CF_W-1:0]     peer_sc;
    wire [`CF_W-1:0]     link_sc;
    wire [`CF_W-1:0]     asym_sc;
    wire [`CF_W-1:0]     resid_sc;
    wire [`SEQ_W+`NS_W-1:0] fifo_out;

    // Nanoseconds to scaled nanoseconds, zero extended.
    function [`CF_W-1:0] scale;
        input [`NS_W-1:0] ns;
        begin
            scale = {{(`CF_W-`NS_W-`CF_FRAC_W){1'b0}}, ns, {`CF_FRAC_W{1'b0}}};
        end
    endfunction

    // Reserved bytes hold time within the second, so the difference
    // wraps across a second boundary; one wrap at most is assumed.
    function [`NS_W-1:0] sub_second_diff;
        input [`NS_W-1:0] a;
        input [`NS_W-1:0] b;
        begin
            if (a >= b) begin
                sub_second_diff = a - b;
            end else begin
                sub_second_diff = a + `NS_PER_SEC - b;
            end
        end
    endfunction

    // Local correction is removed at ingress and added at egress, so
    // both ends of the residence time refer to the same wire point.
    assign live_time_nanoseconds = FRM_EGRESS ?
        CAPTURED_TIME_NS + LOCAL_CORR_NS :
        CAPTURED_TIME_NS - LOCAL_CORR_NS;
    // The peer copy carries the ingress time used by mode B deduct.
    assign live_time_nanoseconds_peer = CAPTURED_TIME_NS - LOCAL_CORR_NS;

    // All correction arithmetic is 64-bit two's complement.
    assign live_sc  = scale(live_time_nanoseconds);
    assign peer_sc  = scale(live_time_nanoseconds_peer);
    assign link_sc  = scale(LINK_DELAY_NS);
    assign asym_sc  = scale(ASYM_NS);
    assign resid_ns = sub_second_diff(live_time_nanoseconds, FRM_RSV);
    assign resid_sc = scale(resid_ns);

    // A frame is taken only while the output slot and FIFO have room,
    // so a stalled engine holds off the analyzer rather than losing t3.
    assign FRM_READY = (state_q == ST_IDLE) && fifo_in_ready;
    assign take      = FRM_VALID & FRM_READY;
    assign RW_VALID  = (state_q == ST_HOLD);

    // Action selection per direction, mode and message kind.
    always @* begin
        ofs_d       = `OFS_NONE;
        size_d      = `SIZE_NONE;
        field_d     = `RST_CF;
        extra_d     = 1'b0;
        extra_val_d = `RST_CF;
        clr_d       = 1'b0;
        flush_d     = 1'b0;
        queue_d     = 1'b0;
        queue_ts_d  = `RST_NS;
        if (!FRM_MATCH || FRM_KIND == `KIND_OTHER) begin
            flush_d = 1'b1;
        end else if (!FRM_EGRESS) begin
            case (FRM_KIND)
                `KIND_SYNC: begin
                    ofs_d  = `OFS_CF;
                    size_d = `SIZE_CF;
                    // Deduct with link delay in both modes.
                    if (MODE_B) begin
                        field_d = FRM_CF - peer_sc + link_sc + asym_sc;
                    end else begin
                        field_d = FRM_CF - live_sc + link_sc + asym_sc;
                    end
                end
                `KIND_PDREQ: begin
                    ofs_d   = `OFS_RSV;
                    size_d  = `SIZE_RSV;
                    field_d = {{(`CF_W-`NS_W){1'b0}}, live_time_nanoseconds};
                end
                `KIND_PDRESP: begin
                    ofs_d  = `OFS_RSV;
                    size_d = `SIZE_RSV;
                    if (MODE_B) begin
                        field_d = {{(`CF_W-`NS_W){1'b0}},
                                   live_time_nanoseconds + ASYM_NS};
                    end else begin
                        field_d     = {{(`CF_W-`NS_W){1'b0}}, live_time_nanoseconds};
                        extra_d     = 1'b1;
                        extra_val_d = FRM_CF + asym_sc;
                    end
                end
                default: begin
                    flush_d = 1'b1;
                end
            endcase
        end else begin
            clr_d = MODE_B;
            case (FRM_KIND)
                `KIND_SYNC: begin
                    ofs_d   = `OFS_CF;
                    size_d  = `SIZE_CF;
                    field_d = FRM_CF + live_sc;
                end
                `KIND_PDREQ: begin
                    if (MODE_B || T3_QUEUE) begin
                        // Insert and queue: nothing written at an offset; mode B clears the reserved bytes.
                        field_d    = {{(`CF_W-`NS_W){1'b0}}, live_time_nanoseconds};
                        queue_d    = 1'b1;
                        queue_ts_d = live_time_nanoseconds - ASYM_NS;
                    end else begin
                        ofs_d   = `OFS_CF;
                        size_d  = `SIZE_CF;
                        field_d = FRM_CF + resid_sc - asym_sc;
                    end
                end
                `KIND_PDRESP: begin
                    ofs_d  = `OFS_CF;
                    size_d = `SIZE_CF;
                    if (MODE_B) begin
                        // Receive time is already out of the correction.
                        field_d = FRM_CF + live_sc;
                    end else begin
                        field_d = FRM_CF + resid_sc;
                    end
                end
                default: begin
                    flush_d = 1'b1;
                end
            endcase
        end
    end

    // Output slot: one frame at a time, held until the rewriter takes it.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (RW_READY) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Rewriter command registers, loaded when a frame is taken.
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            RW_OFFSET       <= `OFS_NONE;
            RW_SIZE         <= `SIZE_NONE;
            RW_NEW_FIELD    <= `RST_CF;
            RW_CF_EXTRA     <= 1'b0;
            RW_CF_EXTRA_VAL <= `RST_CF;
            RW_RSV_CLEAR    <= 1'b0;
            RW_FCS_REDO     <= 1'b0;
            RW_FCS_INVERT   <= 1'b0;
            RW_TS_FLUSH     <= 1'b0;
        end else if (take) begin
            RW_OFFSET       <= ofs_d;
            RW_SIZE         <= size_d;
            RW_NEW_FIELD    <= field_d;
            RW_CF_EXTRA     <= extra_d;
            RW_CF_EXTRA_VAL <= extra_val_d;
            RW_RSV_CLEAR    <= clr_d & ~flush_d;
            RW_TS_FLUSH     <= flush_d;
            // Any change to the frame needs a fresh check sequence; a bad
            // one stays bad so downstream still drops the frame.
            RW_FCS_REDO     <= (size_d != `SIZE_NONE) | extra_d | (clr_d & ~flush_d);
            RW_FCS_INVERT   <= ((size_d != `SIZE_NONE) | extra_d | (clr_d & ~flush_d))
                               & FRM_FCS_BAD;
        end
    end

    // Pairs of sequence identifier and transmit time for the engine.
    ts_fifo #(
        .WIDTH (`SEQ_W + `NS_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_b     (RST_B),
        .in_valid  (take & queue_d),
        .in_ready  (fifo_in_ready),
        .in_data   ({FRM_SEQ, queue_ts_d}),
        .out_valid (FIFO_VALID),
        .out_ready (FIFO_READY),
        .out_data  (fifo_out)
    );

    assign FIFO_SEQ   = fifo_out[`SEQ_W+`NS_W-1:`NS_W];
    assign FIFO_TS_NS = fifo_out[`NS_W-1:0];
endmodule // peer_relay_clock_stamp

/* File: sim/peer_relay_clock_stamp_props.sv */
// Concurrent checks on the ports of the peer relay clock timestamp unit.
`timescale 1ns/1ns
`include "peer_relay_clock_defs.vh"
module peer_relay_clock_stamp_chk (
    input wire               CLK_SYS,
    input wire               RST_B,
    input wire               MODE_B,
    input wire               T3_QUEUE,
    input wire [`NS_W-1:0]   LOCAL_CORR_NS,
    input wire               FRM_VALID,
    input wire               FRM_READY,
    input wire               FRM_EGRESS,
    input wire               FRM_MATCH,
    input wire [`KIND_W-1:0] FRM_KIND,
    input wire               FRM_FCS_BAD,
    input wire [`NS_W-1:0]   CAPTURED_TIME_NS,
    input wire               RW_VALID,
    input wire               RW_READY,
    input wire [`OFS_W-1:0]  RW_OFFSET,
    input wire [`SIZE_W-1:0] RW_SIZE,
    input wire [`CF_W-1:0]   RW_NEW_FIELD,
    input wire               RW_RSV_CLEAR,
    input wire               RW_FCS_REDO,
    input wire               RW_FCS_INVERT,
    input wire               RW_TS_FLUSH,
    input wire               FIFO_VALID
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // A take is one request; a hit is a frame that the analyzer matched to a known kind.
    wire take = FRM_VALID && FRM_READY;
    wire hit  = FRM_MATCH && (FRM_KIND != `KIND_OTHER);
    answer_next_a: assert property (take |=> RW_VALID) else $error("no command after take");
    hold_command_a: assert property (RW_VALID && !RW_READY |=> RW_VALID && $stable(RW_NEW_FIELD) && $stable(RW_SIZE))
        else $error("command changed before accept");
    busy_refuses_a: assert property (RW_VALID |-> !FRM_READY) else $error("request open while busy");
    unmatched_flush_a: assert property (take && !hit |=> RW_TS_FLUSH && !RW_FCS_REDO && !RW_RSV_CLEAR)
        else $error("unmatched frame modified");
    bad_fcs_kept_a: assert property (take && hit && !FRM_EGRESS |=> RW_FCS_REDO && RW_FCS_INVERT == $past(FRM_FCS_BAD))
        else $error("check sequence handling wrong");
    rsv_cleared_a: assert property (take && hit && FRM_EGRESS |=> RW_RSV_CLEAR == $past(MODE_B))
        else $error("reserved clear wrong");
    insert_subsec_a: assert property (take && hit && !FRM_EGRESS && FRM_KIND == `KIND_PDREQ |=> RW_OFFSET == `OFS_RSV
        && RW_SIZE == `SIZE_RSV && RW_NEW_FIELD[31:0] == $past(CAPTURED_TIME_NS) - $past(LOCAL_CORR_NS))
        else $error("receive time insert wrong");
    queue_no_write_a: assert property (take && hit && FRM_EGRESS && FRM_KIND == `KIND_PDREQ && (MODE_B || T3_QUEUE)
        |=> RW_SIZE == `SIZE_NONE && FIFO_VALID) else $error("queued request wrong");
    sync_at_cf_a: assert property (take && hit && FRM_KIND == `KIND_SYNC |=> RW_OFFSET == `OFS_CF && RW_SIZE == `SIZE_CF)
        else $error("sync write place wrong");
    // Main scenarios: egress peer delay request, stalled rewriter, full queue.
    cover property (take && hit && FRM_EGRESS && FRM_KIND == `KIND_PDREQ);
    cover property (RW_VALID && !RW_READY ##1 RW_VALID);
    cover property (FIFO_VALID && !FRM_READY && !RW_VALID);
endmodule // peer_relay_clock_stamp_chk
bind peer_relay_clock_stamp peer_relay_clock_stamp_chk peer_relay_clock_stamp_chk_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .MODE_B(MODE_B),
    .T3_QUEUE(T3_QUEUE), .LOCAL_CORR_NS(LOCAL_CORR_NS), .FRM_VALID(FRM_VALID), .FRM_READY(FRM_READY),
    .FRM_EGRESS(FRM_EGRESS), .FRM_MATCH(FRM_MATCH), .FRM_KIND(FRM_KIND), .FRM_FCS_BAD(FRM_FCS_BAD),
    .CAPTURED_TIME_NS(CAPTURED_TIME_NS), .RW_VALID(RW_VALID), .RW_READY(RW_READY), .RW_OFFSET(RW_OFFSET),
    .RW_SIZE(RW_SIZE), .RW_NEW_FIELD(RW_NEW_FIELD), .RW_RSV_CLEAR(RW_RSV_CLEAR), .RW_FCS_REDO(RW_FCS_REDO),
    .RW_FCS_INVERT(RW_FCS_INVERT), .RW_TS_FLUSH(RW_TS_FLUSH), .FIFO_VALID(FIFO_VALID));

/* File: sim/rw_sink_model.sv */
// Far-side model: frame rewriter sink and timing engine reading the stamp queue.
`timescale 1ns/1ns
module rw_sink_model (
    input  wire clk,
    input  wire stall_fifo,
    output reg  rw_ready,
    output reg  fifo_ready
);
    // Ready moves at the falling edge only, so the unit always samples it settled.
    initial begin
        rw_ready = 1'b0;
        fifo_ready = 1'b0;
    end
    // Random stalls give both prompt and slow acceptance; the engine can stop reading entirely.
    always @(negedge clk) begin
        rw_ready <= ($urandom % 3) != 0;
        fifo_ready <= !stall_fifo && ($urandom % 2);
    end
endmodule // rw_sink_model

/* File: sim/p2p_transparent_clock_stamping_tb_top.sv */
// Self-checking bench for the peer relay clock timestamp unit.
`timescale 1ns/1ns
`include "peer_relay_clock_defs.vh"
module p2p_transparent_clock_stamping_tb_top;
    reg                CLK_SYS, RST_B, MODE_B, T3_QUEUE, FRM_VALID, FRM_EGRESS, FRM_MATCH, FRM_FCS_BAD, stall;
    reg  [`KIND_W-1:0] FRM_KIND;
    reg  [`CF_W-1:0]   FRM_CF;
    reg  [`NS_W-1:0]   LINK_DELAY_NS, ASYM_NS, LOCAL_CORR_NS, FRM_RSV, CAPTURED_TIME_NS;
    reg  [`SEQ_W-1:0]  FRM_SEQ;
    wire               FRM_READY, RW_VALID, RW_READY, RW_CF_EXTRA, RW_RSV_CLEAR, RW_FCS_REDO, RW_FCS_INVERT;
    wire               RW_TS_FLUSH, FIFO_VALID, FIFO_READY;
    wire [`OFS_W-1:0]  RW_OFFSET;
    wire [`SIZE_W-1:0] RW_SIZE;
    wire [`CF_W-1:0]   RW_NEW_FIELD, RW_CF_EXTRA_VAL;
    wire [`SEQ_W-1:0]  FIFO_SEQ;
    wire [`NS_W-1:0]   FIFO_TS_NS;
    reg  [144:0]       exp_q[$];
    reg  [47:0]        fifo_q[$];
    reg  [144:0]       e;
    reg  [47:0]        f;
    integer            error_cnt, n_checks, cyc, i;

    peer_relay_clock_stamp peer_relay_clock_stamp_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .MODE_B(MODE_B), .T3_QUEUE(T3_QUEUE),
        .LINK_DELAY_NS(LINK_DELAY_NS), .ASYM_NS(ASYM_NS), .LOCAL_CORR_NS(LOCAL_CORR_NS), .FRM_VALID(FRM_VALID),
        .FRM_READY(FRM_READY), .FRM_EGRESS(FRM_EGRESS), .FRM_MATCH(FRM_MATCH), .FRM_KIND(FRM_KIND),
        .FRM_CF(FRM_CF), .FRM_RSV(FRM_RSV), .FRM_SEQ(FRM_SEQ), .FRM_FCS_BAD(FRM_FCS_BAD),
        .CAPTURED_TIME_NS(CAPTURED_TIME_NS), .RW_VALID(RW_VALID), .RW_READY(RW_READY), .RW_OFFSET(RW_OFFSET),
        .RW_SIZE(RW_SIZE), .RW_NEW_FIELD(RW_NEW_FIELD), .RW_CF_EXTRA(RW_CF_EXTRA),
        .RW_CF_EXTRA_VAL(RW_CF_EXTRA_VAL), .RW_RSV_CLEAR(RW_RSV_CLEAR), .RW_FCS_REDO(RW_FCS_REDO),
        .RW_FCS_INVERT(RW_FCS_INVERT), .RW_TS_FLUSH(RW_TS_FLUSH), .FIFO_VALID(FIFO_VALID),
        .FIFO_READY(FIFO_READY), .FIFO_SEQ(FIFO_SEQ), .FIFO_TS_NS(FIFO_TS_NS));
    rw_sink_model rw_sink_model_inst (.clk(CLK_SYS), .stall_fifo(stall), .rw_ready(RW_READY),
        .fifo_ready(FIFO_READY));

    // Scaled nanoseconds carry 16 fraction bits.
    function [63:0] sc(input [31:0] n);
        sc = {16'h0, n, 16'h0};
    endfunction

    task check(input [79:0] s, input [79:0] x);
        begin
            n_checks = n_checks + 1;
            if (s !== x) begin
                error_cnt = error_cnt + 1;
                $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
            end
        end
    endtask

    task close_out;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // Drives one analyzer request, noting the expected command and any queue entry first.
    task send(input mb, input t3, input eg, input mt, input [1:0] k, input wrap);
        reg [31:0] raw, live, rsv, d;
        reg [63:0] cf, fv, xv;
        reg [15:0] seq;
        reg [7:0]  o;
        reg [3:0]  z;
        reg        x, q, fl, bad, rd;
        integer    n;
        begin
            raw = 32'h100000 + $urandom % 32'h10000000;
            seq = $urandom;
            bad = $urandom % 2;
            live = eg ? raw + LOCAL_CORR_NS : raw - LOCAL_CORR_NS;
            rsv = wrap ? live + 32'h64 : live - $urandom % 32'h10000;
            cf = (eg && k == `KIND_PDREQ) ? 64'h0 : {$urandom, $urandom};
            {o, z, fv, q} = {`OFS_CF, `SIZE_CF, 64'h0, 1'b0};
            fl = !mt || k == `KIND_OTHER;
            d = live - rsv + ((live < rsv) ? `NS_PER_SEC : 32'h0);
            if (!eg && k == `KIND_SYNC)
                fv = cf - sc(live) + sc(LINK_DELAY_NS) + sc(ASYM_NS);
            if (!eg && k != `KIND_SYNC)
                {o, z, fv} = {`OFS_RSV, `SIZE_RSV, 32'h0, (mb && k == `KIND_PDRESP) ? live + ASYM_NS : live};
            x = !fl && !eg && !mb && k == `KIND_PDRESP;
            xv = x ? cf + sc(ASYM_NS) : 64'h0;
            if (eg && k == `KIND_SYNC)
                fv = cf + sc(live);
            if (eg && k == `KIND_PDREQ)
                q = mb || t3;
            if (eg && k == `KIND_PDREQ)
                {o, z, fv} = q ? {`OFS_NONE, `SIZE_NONE, 32'h0, live} : {`OFS_CF, `SIZE_CF, cf + sc(d) - sc(ASYM_NS)};
            if (eg && k == `KIND_PDRESP)
                fv = mb ? cf + sc(live) : cf + sc(d);
            q = q && !fl;
            rd = !fl && !(q && !mb);
            exp_q.push_back({o, z, fv, x, xv, mb && eg && !fl, rd, rd && bad, fl});
            if (q)
                fifo_q.push_back({seq, live - ASYM_NS});
            @(negedge CLK_SYS);
            {MODE_B, T3_QUEUE, FRM_EGRESS, FRM_MATCH, FRM_KIND, FRM_CF} = {mb, t3, eg, mt, k, cf};
            {FRM_RSV, FRM_SEQ, FRM_FCS_BAD, CAPTURED_TIME_NS, FRM_VALID} = {rsv, seq, bad, raw, 1'b1};
            n = 0;
            while (FRM_READY !== 1'b1 && n < 60) begin
                @(negedge CLK_SYS);
                n = n + 1;
            end
            @(posedge CLK_SYS);
        end
    endtask

    // Drops the request line and waits, bounded, for every noted result to appear.
    task drain(input [63:0] name);
        integer n;
        begin
            @(negedge CLK_SYS);
            FRM_VALID = 1'b0;
            n = 0;
            while ((exp_q.size() || fifo_q.size()) && n < 80) begin
                @(negedge CLK_SYS);
                n = n + 1;
            end
            check(exp_q.size() + fifo_q.size(), 0);
            $display("test %0s done", name);
        end
    endtask

    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // Result watcher: each accepted command or popped entry is compared with the oldest note.
    always @(posedge CLK_SYS) begin
        if (RST_B && RW_VALID && RW_READY) begin
            e = exp_q.size() ? exp_q.pop_front() : {145{1'b1}};
            if (!e[0])
                // A queued request writes nothing at an offset, yet still hands the transmit time to the rewriter.
                check({(e[136:133] != 4'h0) ? RW_OFFSET : 8'h0, RW_SIZE, (e[136:133] == 4'h8) ? RW_NEW_FIELD :
                    {32'h0, RW_NEW_FIELD[31:0]}}, e[144:69]);
            check({RW_CF_EXTRA, e[68] ? RW_CF_EXTRA_VAL : 64'h0, RW_RSV_CLEAR, RW_FCS_REDO, RW_FCS_INVERT,
                RW_TS_FLUSH}, e[68:0]);
        end
        if (RST_B && FIFO_VALID && FIFO_READY) begin
            f = fifo_q.size() ? fifo_q.pop_front() : 48'hffffffffffff;
            check({FIFO_SEQ, FIFO_TS_NS}, f);
        end
        cyc = cyc + 1;
        if (cyc == 4000) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
    end

    initial begin
        {RST_B, MODE_B, T3_QUEUE, FRM_VALID, FRM_EGRESS, FRM_MATCH, FRM_FCS_BAD, stall, FRM_KIND} = 10'h0;
        {FRM_CF, FRM_RSV, CAPTURED_TIME_NS, FRM_SEQ} = 144'h0;
        {error_cnt, n_checks, cyc} = 96'h0;
        i = $urandom(32'h683b);
        LINK_DELAY_NS = $urandom % 32'h10000;
        ASYM_NS = $urandom % 32'h1000;
        LOCAL_CORR_NS = $urandom % 32'h10000;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        RST_B = 1'b1;
        // Every mode, queue choice, direction, kind and match state, back to back.
        for (i = 0; i < 64; i = i + 1)
            send(i[5], i[4], i[3], i[2], i[1:0], 1'b0);
        drain("all");
        send(1'b0, 1'b0, 1'b1, 1'b1, `KIND_PDREQ, 1'b1);
        drain("wrap");
        // With the engine not reading, eight queued requests must fill the queue and refuse more.
        stall = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            send(1'b1, 1'b0, 1'b1, 1'b1, `KIND_PDREQ, 1'b0);
        @(negedge CLK_SYS);
        FRM_VALID = 1'b0;
        while (RW_VALID === 1'b1 && cyc < 3000)
            @(negedge CLK_SYS);
        @(negedge CLK_SYS);
        check(FRM_READY, 1'b0);
        stall = 1'b0;
        drain("full");
        check(FIFO_VALID, 1'b0);
        // A reset in mid-run drops a pending command and a queued entry.
        stall = 1'b1;
        send(1'b1, 1'b0, 1'b1, 1'b1, `KIND_PDREQ, 1'b0);
        @(negedge CLK_SYS);
        {FRM_VALID, RST_B} = 2'b00;
        exp_q.delete();
        fifo_q.delete();
        @(negedge CLK_SYS);
        check({RW_VALID, FIFO_VALID, FRM_READY, RW_TS_FLUSH}, 4'h2);
        {RST_B, stall} = 2'b10;
        send(1'b0, 1'b0, 1'b0, 1'b1, `KIND_SYNC, 1'b0);
        drain("reset");
        close_out;
    end
endmodule // p2p_transparent_clock_stamping_tb_top
